/* core/pic_pkg.sv */
/*
 types for the interrupt controller.
 assumes the offsets and counts of pic_regs.svh.
*/
`default_nettype none
package pic_pkg;
   typedef enum logic [1:0]
   {
      ST_RUN  = 2'b00,
      ST_CALL = 2'b01,
      ST_JMP  = 2'b10
   } seq_state_e;
   typedef struct packed
   {
      logic       ep_done;   // final handshake seen
      logic [4:0] ep_id;     // one bit each: a0..a2 as bits 0..2, b0..b1 as bits 3..4
   } ep_event_s;
   typedef struct packed
   {
      logic [3:0] pins;
      logic [3:0] pol;       // 1 rising, 0 falling
      logic [3:0] en;
   } pin_group_s;
endpackage : pic_pkg
`default_nettype wire

/* core/pic_regs.svh */
/*
 interrupt controller register offsets, field positions, reset values and timing counts.
 assumes a 125 MHz aclk and 32-bit AXI4-Lite registers at byte addresses four apart.
*/
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
// register byte offsets
`define OFS_GLOBAL_EN      6'h00
`define OFS_EP_EN          6'h04
`define OFS_STATUS         6'h08
`define OFS_PENDING        6'h0c
`define OFS_CPU_CMD        6'h10
`define OFS_VECTOR         6'h14
`define OFS_GPIO_CFG       6'h18
`define OFS_DAC_CFG        6'h1c
// global enable fields
`define GEN_BUSRST         0
`define GEN_T128           1
`define GEN_T1024          2
`define GEN_DAC            4
`define GEN_GPIO           5
`define GEN_I2C            6
`define GEN_MASK           8'h77
`define EP_MASK            8'h1f
// status fields
`define ST_IE_SENSE        2
`define ST_BUSRST          5
`define ST_IRQ_PEND        7
// reset values
`define RST_GLOBAL_EN      8'h00
`define RST_EP_EN          8'h00
`define RESET_VECTOR       16'h0000
// timing
`define CLK_MHZ            125
`define SE0_MIN_US         12
`define SE0_CYCLES         (`SE0_MIN_US * `CLK_MHZ)
`define CALL_CYCLES        10
`define JMP_CYCLES         5
`endif

/* core/priority_interrupt_controller.sv */
/*
 priority interrupt controller with AXI4-Lite registers and a forced-call sequencer.
 assumes the core signals instruction boundaries and return/enable/disable instructions,
 sources give one-cycle events, and pins are asynchronous.
*/
// Behaviour
// - endpoint enable: bits 0-2 endpoints a0-a2, bits 3-4 b0-b1, top reserved
// - any reset clears global and endpoint enable registers
// - each source has its own pending flop held until serviced or reset
// - pending flag requests service only while its enable is set
// - only highest active request served, only at an instruction boundary
// - service clears global enable, then pending, then calls the vector
// - forced call pushes program counter with carry and zero flags
// - return from interrupt restores pc and flags and sets global enable
// - enable/disable touch only global enable; pending still shows at status bit 7
// - vector 1 bus reset highest, vector 12 lowest priority
// - after any reset execution starts at address 0x0000
// - vectors two bytes apart: bus reset 0x0002, timers 0x0004 and 0x0006
// - endpoints 0x0008-0x0010, 0x0012 reserved, dac 0x0014, gpio 0x0016, i2c 0x0018
// - latency is remaining cycles plus 10 for call plus 5 for jump
// - se0 lasting 12 us detects bus reset and sets status bit 5
// - bus reset interrupt raised when se0 ends; it aborts start-up delay
// - detected bus reset clears device address registers
// - endpoint interrupt on final ack; unacked in raises none
// - dac pins edge by polarity, share one vector without priority
// - after a dac trigger others blocked until pin inactive or disabled
// - gpio shares vector, per-port polarity, lockout, enables survive acknowledge
// - parallel host port owns gpio vector, gated only by global bit 5
// - global enable: bit0 bus reset, 1 and 2 timers, 4 dac, 5 gpio, 6 i2c
`include "pic_regs.svh"
`default_nettype none
module priority_interrupt_controller
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [5:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [5:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                se0_pin,
   input  wire logic                tick_128us,
   input  wire logic                tick_1024ms,
   input  wire pic_pkg::ep_event_s  ep_event,
   input  wire logic                ep_in_nak,
   input  wire logic [3:0]          dac_pins,
   input  wire logic [7:0]          gpio_pins,
   input  wire logic                parallel_host_port,
   input  wire logic                parallel_host_port_evt,
   input  wire logic                i2c_evt,
   input  wire logic                instr_done,
   input  wire logic                return_from_interrupt,
   input  wire logic                enable_interrupts_instr,
   input  wire logic                disable_interrupts_instr,
   input  wire logic [15:0]         pc,
   input  wire logic                carry_flag,
   input  wire logic                zero_flag,
   output logic                     push_req,
   output logic [17:0]              push_data,
   output logic                     restore_req,
   output logic                     force_call,
   output logic [15:0]              vector_addr,
   output logic                     seq_busy,
   output logic                     startup_abort,
   output logic                     dev_addr_clear
);

////////////////////////////////////////////////////////////////////////////////
   localparam int NSRC = 12;

   function automatic logic [3:0] pick_vector(input logic [NSRC:1] req);
      logic [3:0] v;
      v = 4'h0;
      for (int i = NSRC; i >= 1; i--)
      begin
         if (req[i])
            v = 4'(i);   // lowest number wins
      end
      return v;
   endfunction : pick_vector

   function automatic logic [15:0] vec_to_addr(input logic [3:0] v);
      return {11'h000, v, 1'b0};   // two-byte entries
   endfunction : vec_to_addr

////////////////////////////////////////////////////////////////////////////////
   logic [7:0]   global_en_ff;
   logic [7:0]   ep_en_ff;
   logic         gie_ff;
   logic         busrst_stat_ff;
   logic [NSRC:1] pend_ff;
   logic [NSRC:1] nxt_pend;
   logic [NSRC:1] enab;
   logic [NSRC:1] req;
   logic [NSRC:1] evt;
   logic [3:0]   vec_ff;
   logic [3:0]   cnt_ff;
   pic_pkg::seq_state_e state_ff;
   pic_pkg::pin_group_s dac_cfg_ff;
   logic [7:0]   gpio_pol_ff;
   logic [7:0]   gpio_en_ff;

   // pin synchronisers: three flops, change counted when stages two and three agree
   logic [12:0]  pin_s1_ff;
   logic [12:0]  pin_s2_ff;
   logic [12:0]  pin_s3_ff;
   logic [12:0]  pin_q_ff;
   logic [12:0]  pin_prev_ff;
   logic [12:0]  pin_raw;
   assign pin_raw = {se0_pin, gpio_pins, dac_pins};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_ff   <= 13'h0000;
         pin_s2_ff   <= 13'h0000;
         pin_s3_ff   <= 13'h0000;
         pin_q_ff    <= 13'h0000;
         pin_prev_ff <= 13'h0000;
      end
      else
      begin
         pin_s1_ff   <= pin_raw;
         pin_s2_ff   <= pin_s1_ff;
         pin_s3_ff   <= pin_s2_ff;
         pin_q_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_q_ff & (pin_s2_ff | pin_s3_ff));
         pin_prev_ff <= pin_q_ff;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // bus reset detect: long se0 arms, its end raises the event
   logic [11:0]  se0_cnt_ff;
   logic         se0_armed_ff;
   wire  logic   se0_now = pin_q_ff[12];
   wire  logic   busrst_evt = se0_armed_ff & ~se0_now;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         se0_cnt_ff   <= 12'h000;
         se0_armed_ff <= 1'b0;
      end
      else if (!se0_now)
      begin
         se0_cnt_ff   <= 12'h000;
         se0_armed_ff <= 1'b0;
      end
      else if (se0_cnt_ff == 12'(`SE0_CYCLES - 1))
         se0_armed_ff <= 1'b1;   // 12 us of se0
      else
         se0_cnt_ff <= se0_cnt_ff + 12'h001;
   end

   // start-up delay abort and address clear stay high from detection until se0 ends
   assign startup_abort  = se0_armed_ff;
   assign dev_addr_clear = se0_armed_ff;

////////////////////////////////////////////////////////////////////////////////
   // shared-vector pins with lockout: one active pin blocks others
   logic [3:0] dac_act;
   logic [7:0] gpio_act;
   logic       dac_lock_ff;
   logic       gpio_lock_ff;
   logic       dac_evt;
   logic       gpio_evt;

   assign dac_act  = ~(pin_q_ff[3:0] ^ dac_cfg_ff.pol) & dac_cfg_ff.en;
   assign gpio_act = ~(pin_q_ff[11:4] ^ gpio_pol_ff) & gpio_en_ff;
   assign dac_evt  = !dac_lock_ff && |dac_act;
   // parallel host port blocks pin events and takes the vector
   assign gpio_evt = parallel_host_port ? parallel_host_port_evt : (!gpio_lock_ff && |gpio_act);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dac_lock_ff  <= 1'b0;
         gpio_lock_ff <= 1'b0;
      end
      else
      begin
         dac_lock_ff  <= |dac_act;    // released when pin inactive or disabled
         gpio_lock_ff <= |gpio_act;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // ack on final handshake only; an unacked in is dropped by ep_in_nak even with ep_done high
   logic [4:0] ep_evt;
   assign ep_evt = (ep_event.ep_done && !ep_in_nak) ? ep_event.ep_id : 5'h00;
   assign evt = {i2c_evt, gpio_evt, dac_evt, 1'b0, ep_evt, tick_1024ms, tick_128us, busrst_evt};

   // ep enable bits map a0..a2 and b0..b1 onto vectors 4..8
   assign enab = {global_en_ff[`GEN_I2C], global_en_ff[`GEN_GPIO], global_en_ff[`GEN_DAC], 1'b0,
                  ep_en_ff[4:0], global_en_ff[`GEN_T1024], global_en_ff[`GEN_T128],
                  global_en_ff[`GEN_BUSRST]};
   assign req = pend_ff & enab;   // disabled pending stays latched

   always_comb
   begin
      nxt_pend = pend_ff;
      if (state_ff == pic_pkg::ST_RUN && instr_done && gie_ff && |req)
         nxt_pend[pick_vector(req)] = 1'b0;   // clear serviced flop
      nxt_pend = nxt_pend | evt;              // a new event wins over the clear
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pend_ff <= 12'h000;
      else
         pend_ff <= nxt_pend;
   end

////////////////////////////////////////////////////////////////////////////////
   // sequencer: call phase then jump phase
   wire logic take = state_ff == pic_pkg::ST_RUN && instr_done && gie_ff && |req;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff <= pic_pkg::ST_RUN;
         cnt_ff   <= 4'h0;
         vec_ff   <= 4'h0;
      end
      else
      begin
         unique case (state_ff)
            pic_pkg::ST_RUN:
            begin
               if (take)
               begin
                  state_ff <= pic_pkg::ST_CALL;
                  cnt_ff   <= 4'(`CALL_CYCLES - 1);
                  vec_ff   <= pick_vector(req);
               end
            end
            pic_pkg::ST_CALL:
            begin
               if (cnt_ff == 4'h0)
               begin
                  state_ff <= pic_pkg::ST_JMP;
                  cnt_ff   <= 4'(`JMP_CYCLES - 1);
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            end
            pic_pkg::ST_JMP:
            begin
               if (cnt_ff == 4'h0)
                  state_ff <= pic_pkg::ST_RUN;
               else
                  cnt_ff <= cnt_ff - 4'h1;
            end
            default:
               state_ff <= pic_pkg::ST_RUN;
         endcase
      end
   end

   assign seq_busy    = state_ff != pic_pkg::ST_RUN;
   assign force_call  = take;
   assign push_req    = take;
   assign push_data   = {carry_flag, zero_flag, pc};
   assign restore_req = return_from_interrupt;
   assign vector_addr = aresetn ? vec_to_addr(vec_ff) : `RESET_VECTOR;

   // global enable inside the core; cleared first on service
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gie_ff <= 1'b0;
      else if (take)
         gie_ff <= 1'b0;
      else if (return_from_interrupt || enable_interrupts_instr)
         gie_ff <= 1'b1;
      else if (disable_interrupts_instr)
         gie_ff <= 1'b0;
   end

////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: one write and one read at a time, answer a cycle after both halves
   logic [5:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        aw_ok_ff;
   logic        w_ok_ff;
   wire  logic  do_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

   assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_ff     <= 1'b0;
         w_ok_ff      <= 1'b0;
         awaddr_ff    <= 6'h00;
         wdata_ff     <= 32'h0000_0000;
         wstrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff > `OFS_DAC_CFG) ? 2'b10 : 2'b00;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // software writable configuration; only strobe bit 0 gates a write, gpio and dac config also take data from byte lane 1
   wire logic wr_b0 = do_wr && wstrb_ff[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_en_ff <= `RST_GLOBAL_EN;
         ep_en_ff     <= `RST_EP_EN;
         dac_cfg_ff   <= '0;
         gpio_pol_ff  <= 8'h00;
         gpio_en_ff   <= 8'h00;
      end
      else if (wr_b0)
      begin
         unique case (awaddr_ff)
            `OFS_GLOBAL_EN: global_en_ff <= wdata_ff[7:0] & `GEN_MASK;
            `OFS_EP_EN:     ep_en_ff     <= wdata_ff[7:0] & `EP_MASK;
            `OFS_DAC_CFG:   dac_cfg_ff   <= wdata_ff[11:0];
            `OFS_GPIO_CFG:
            begin
               gpio_pol_ff <= wdata_ff[7:0];
               gpio_en_ff  <= wdata_ff[15:8];
            end
            default: ;
         endcase
      end
   end

   // bus reset status bit: set wins over write-zero clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         busrst_stat_ff <= 1'b0;
      else if (busrst_evt)
         busrst_stat_ff <= 1'b1;
      else if (wr_b0 && awaddr_ff == `OFS_STATUS && !wdata_ff[`ST_BUSRST])
         busrst_stat_ff <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         unique case (s_axi_araddr)
            `OFS_GLOBAL_EN: s_axi_rdata <= {24'h0, global_en_ff};
            `OFS_EP_EN:     s_axi_rdata <= {24'h0, ep_en_ff};   // reserved read zero
            // pending seen even with global enable clear
            `OFS_STATUS:    s_axi_rdata <= {24'h0, |req, 1'b0, busrst_stat_ff, 2'b00, gie_ff, 2'b00};
            `OFS_PENDING:   s_axi_rdata <= {19'h0, pend_ff, 1'b0};
            `OFS_CPU_CMD:   s_axi_rdata <= {30'h0, seq_busy, gie_ff};
            `OFS_VECTOR:    s_axi_rdata <= {16'h0, vector_addr};
            `OFS_GPIO_CFG:  s_axi_rdata <= {16'h0, gpio_en_ff, gpio_pol_ff};
            `OFS_DAC_CFG:   s_axi_rdata <= {20'h0, dac_cfg_ff};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

////////////////////////////////////////////////////////////////////////////////
   AST_SERVE_CLEARS_GIE: assert property (@(posedge aclk) disable iff (!aresetn)
      take |=> !gie_ff) else $error("global enable not cleared on service");
   // end points of each phase; the counter cannot leave a phase early
   AST_CALL_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
      take |=> (state_ff == pic_pkg::ST_CALL) ##9 (state_ff == pic_pkg::ST_CALL)
      ##1 (state_ff == pic_pkg::ST_JMP) ##4 (state_ff == pic_pkg::ST_JMP)
      ##1 (state_ff == pic_pkg::ST_RUN)) else $error("call or jump length wrong");
   AST_ONLY_ENABLED: assert property (@(posedge aclk) disable iff (!aresetn)
      take |-> gie_ff && (req[pick_vector(req)] == 1'b1)
      && ((req & ~({NSRC{1'b1}} << (pick_vector(req) - 4'h1))) == '0)) else $error("service without request");
   AST_PEND_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !evt[pick_vector(req)] |=> !pend_ff[vec_ff])
      else $error("pending flop not cleared");
   AST_VEC_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
      take |=> vector_addr == 16'(vec_ff) * 16'h0002 && vec_ff >= 4'h1 && vec_ff <= 4'hc)
      else $error("vector address wrong");
   AST_RETURN_FROM_INTERRUPT_GIE: assert property (@(posedge aclk) disable iff (!aresetn)
      return_from_interrupt && !take |=> gie_ff) else $error("return did not enable");
   AST_PEND_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      pend_ff[3] && !take |=> pend_ff[3]) else $error("pending lost");
   AST_BOUNDARY: assert property (@(posedge aclk) disable iff (!aresetn)
      force_call |-> instr_done && state_ff == pic_pkg::ST_RUN) else $error("call off boundary");
   AST_BUSRST_STAT: assert property (@(posedge aclk) disable iff (!aresetn)
      busrst_evt |=> busrst_stat_ff && pend_ff[1]) else $error("bus reset not recorded");

endmodule : priority_interrupt_controller
`default_nettype wire

/* verif/core_model.sv */
/*
 core model: four-cycle instructions, program counter and flags; records each forced call.
 assumes the controller drives force_call, push_data and seq_busy; reset is synchronous, active low.
*/
`default_nettype none
module core_model
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        force_call,
   input  wire logic [17:0] push_data,
   input  wire logic        seq_busy,
   output logic             instr_done,
   output logic [15:0]      pc,
   output logic             carry_flag,
   output logic             zero_flag,
   output int               calls,
   output logic [17:0]      pushed,
   output logic [17:0]      snap,
   output int               busy_len
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] step_ff;
   initial
   begin
      {instr_done, carry_flag, zero_flag, step_ff} = 5'h00;
      pc = 16'h0100;
      calls = 0;
      busy_len = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // no boundary while the forced call runs: the core is busy executing it
   always @(posedge aclk)
   begin
      step_ff <= aresetn ? step_ff + 2'h1 : 2'h0;
      instr_done <= aresetn && step_ff == 2'h2 && !seq_busy;
      if (instr_done)
      begin
         pc <= pc + 16'h0001;
         {carry_flag, zero_flag} <= pc[1:0];
      end
      if (force_call)
      begin
         calls <= calls + 1;
         pushed <= push_data;
         snap <= {carry_flag, zero_flag, pc};
         busy_len <= 0;
      end
      else if (seq_busy)
         busy_len <= busy_len + 1;
   end
endmodule : core_model
`default_nettype wire

/* verif/priority_interrupt_controller_bench.sv */
/*
 bench for the interrupt controller: axi4-lite register tasks and service sequences.
 assumes core_model as the processor core and the offsets of pic_regs.svh.
*/
`include "pic_regs.svh"
`default_nettype none
module priority_interrupt_controller_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb;
   logic [1:0]          s_axi_bresp, s_axi_rresp, last_resp;
   logic                aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic                se0_pin, instr_done, carry_flag, zero_flag, push_req, restore_req, force_call;
   logic                seq_busy, startup_abort, dev_addr_clear;
   logic [12:0]         ev;
   logic [7:0]          gpio;
   logic [2:0]          op;
   logic [15:0]         pc, vector_addr;
   logic [17:0]         push_data, pushed, snap;
   int                  calls, busy_len, cycles, miscompares, cmp_count;
   pic_pkg::ep_event_s  ep;
   assign ep = pic_pkg::ep_event_s'({|ev[8:4], ev[8:4]});
   always #4 aclk = ~aclk;
   priority_interrupt_controller i_priority_interrupt_controller
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .se0_pin, .tick_128us(ev[2]), .tick_1024ms(ev[3]), .ep_event(ep), .ep_in_nak(ev[9]),
      .dac_pins(4'h0), .gpio_pins(gpio), .parallel_host_port(1'b0), .parallel_host_port_evt(1'b0),
      .i2c_evt(ev[12]), .instr_done, .return_from_interrupt(op[2]), .enable_interrupts_instr(op[0]),
      .disable_interrupts_instr(op[1]), .pc, .carry_flag, .zero_flag, .push_req, .push_data,
      .restore_req, .force_call, .vector_addr, .seq_busy, .startup_abort, .dev_addr_clear
   );
   core_model i_core_model
   (
      .aclk, .aresetn, .force_call, .push_data, .seq_busy, .instr_done, .pc, .carry_flag,
      .zero_flag, .calls, .pushed, .snap, .busy_len
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      last_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      last_resp = s_axi_rresp;
      chk(s_axi_rdata, exp);
   endtask : rd
   task automatic pulse(input logic [12:0] e, input logic [2:0] o);
      @(posedge aclk);
      ev <= e;
      op <= o;
      @(posedge aclk);
      chk(restore_req, o[2]);
      ev <= 13'h0000;
      op <= 3'h0;
   endtask : pulse
   // waits for one forced call and its full call and jump
   task automatic serve(input logic [15:0] v);
      int n;
      n = calls;
      do @(posedge aclk); while (calls == n);
      while (seq_busy) @(posedge aclk);
      chk(vector_addr, v);
      chk(busy_len, `CALL_CYCLES + `JMP_CYCLES);
      chk(pushed, snap);
   endtask : serve
   task automatic end_sim;
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         miscompares++;
         $display("wrong value at %0t: timeout", $time);
         end_sim();
      end
   end
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, se0_pin} = 6'h00;
      s_axi_awaddr = 6'h00;
      s_axi_araddr = 6'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h1;
      ev = 13'h0000;
      gpio = 8'h00;
      op = 3'h0;
      cycles = 0;
      miscompares = 0;
      cmp_count = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFS_GLOBAL_EN, 32'h0000_0000);
      rd(`OFS_EP_EN, 32'h0000_0000);
      chk(vector_addr, 32'h0000_0000);
      wr(`OFS_GLOBAL_EN, 32'h0000_00ff);
      chk(last_resp, 32'h0000_0000);
      rd(`OFS_GLOBAL_EN, 32'h0000_0077);
      wr(`OFS_EP_EN, 32'h0000_00ff);
      rd(`OFS_EP_EN, 32'h0000_001f);
      rd(6'h20, 32'h0000_0000);
      chk(last_resp, 32'h0000_0002);
      wr(6'h20, 32'h0000_0000);
      chk(last_resp, 32'h0000_0002);
      // latched while masked, no request shown
      wr(`OFS_GLOBAL_EN, 32'h0000_0000);
      pulse(13'h1008, 3'h0);
      rd(`OFS_PENDING, 32'h0000_1008);
      rd(`OFS_STATUS, 32'h0000_0000);
      wr(`OFS_GLOBAL_EN, 32'h0000_0077);
      rd(`OFS_STATUS, 32'h0000_0080);
      pulse(13'h0004, 3'h1);
      serve(16'h0004);
      rd(`OFS_CPU_CMD, 32'h0000_0000);
      rd(`OFS_PENDING, 32'h0000_1008);
      pulse(13'h0000, 3'h4);
      serve(16'h0006);
      pulse(13'h0000, 3'h4);
      serve(16'h0018);
      for (int k = 4; k <= 8; k++)
      begin
         pulse(13'h0001 << k, 3'h4);
         serve(16'(2 * k));
      end
      // endpoint a0 in without ack leaves nothing pending
      pulse(13'h0210, 3'h0);
      rd(`OFS_PENDING, 32'h0000_0000);
      wr(`OFS_GPIO_CFG, 32'h0000_0101);
      gpio <= 8'h01;
      repeat (6) @(posedge aclk);
      rd(`OFS_PENDING, 32'h0000_0800);
      @(posedge aclk);
      se0_pin <= 1'b1;
      repeat (1520) @(posedge aclk);
      chk(startup_abort, 32'h0000_0001);
      chk(dev_addr_clear, 32'h0000_0001);
      se0_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(`OFS_STATUS, 32'h0000_00a0);
      pulse(13'h0000, 3'h4);
      serve(16'h0002);
      end_sim();
   end
endmodule : priority_interrupt_controller_bench
`default_nettype wire
